// *** rtl/dpc_ctrl.sv ***
/*
 * device-side power-down, reset and on-die termination control.
 * assumes commands and cke come from the memory controller on core_clk,
 * dram_reset_n and odt_pin are asynchronous pins.
 */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - open bank at entry gives active power-down
// - all banks closed gives precharge power-down
// - exit bit picks fast or slow exit
// - active power-down keeps dll, fast exit
// - reset low in power-down goes to reset
// - exit on cke high with nop
// - write recovery count from mr0 bits
// - reset acts whenever it falls low
// - reset disables outputs, termination, state
// - reset clears refresh counters
// - no termination with dll disabled
// - ignore termination pin in self refresh
// - termination asynchronous in slow-exit precharge power-down
// - dynamic termination only during write bursts
// - enter power-down on cke low with nop
module dpc_ctrl
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic dram_reset_n,
	input wire logic cke,
	input wire logic [3:0] cmd,
	input wire logic cmd_busy,
	input wire logic [7:0] bank_open,
	input wire logic mr_load,
	input wire logic [1:0] mr_sel,
	input wire logic [15:0] mr_data,
	input wire logic dll_disable,
	input wire logic write_burst,
	input wire logic odt_pin,
	output logic [dpc_pkg::DPC_MR0_WR_HI-dpc_pkg::DPC_MR0_WR_LO:0] wr_recovery,
	output logic dll_on,
	output logic odt_async,
	output logic odt_active,
	output logic [1:0] term_sel,
	output logic out_enable,
	output logic in_reset,
	output logic active_pd,
	output logic precharge_pd,
	output logic slow_exit,
	output logic relock_busy,
	output logic [15:0] refresh_count
);
	import dpc_pkg::*;

	dpc_state_t state_r;
	dpc_state_t state_nxt;
	logic [15:0] mr0_r;
	logic [15:0] mr0_nxt;
	logic [15:0] mr1_r;
	logic [15:0] mr1_nxt;
	logic [15:0] mr2_r;
	logic [15:0] mr2_nxt;
	logic [3:0] relock_r;
	logic [3:0] relock_nxt;
	logic [15:0] refcnt_r;
	logic [15:0] refcnt_nxt;
	logic [1:0] term_r;
	logic [1:0] term_nxt;
	logic odt_act_r;
	logic odt_act_nxt;
	logic reset_s;
	logic odt_s;
	logic idle_cmd;
	logic nom_en;
	logic wr_en;
	logic dll_run;
	logic term_allowed;

	// ****************************************
	// pin synchronisers
	// ****************************************
	dpc_sync #(.RST_VAL(1'b0)) u_reset_sync
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(dram_reset_n),
		.sync_out(reset_s)
	);

	dpc_sync #(.RST_VAL(1'b0)) u_odt_sync
	(
		.core_clk(core_clk),
		.rst_n(rst_n),
		.async_in(odt_pin),
		.sync_out(odt_s)
	);

	// nop, or deselect when chip select is high
	assign idle_cmd = (cmd == DPC_CMD_NOP) || ((cmd & DPC_CMD_DES_MASK) == DPC_CMD_DES_MASK);

	// ****************************************
	// power state machine
	// ****************************************
	always_comb
	begin
		state_nxt = state_r;
		relock_nxt = (relock_r != 4'h0) ? relock_r - 4'h1 : 4'h0;
		refcnt_nxt = refcnt_r;
		case (state_r)
			DPC_ST_RESET:
			begin
				if (reset_s)
				begin
					state_nxt = DPC_ST_IDLE;
				end
			end
			DPC_ST_IDLE:
			begin
				if (cke && cmd == DPC_CMD_REF)
				begin
					refcnt_nxt = refcnt_r + 16'h0001;
				end
				if (!cke && cmd == DPC_CMD_SREF)
				begin
					state_nxt = DPC_ST_SELF_REF;
				end
				else if (!cke && idle_cmd && !cmd_busy)
				begin
					if (|bank_open)
					begin
						state_nxt = DPC_ST_ACT_PD;
					end
					else if (mr0_r[DPC_MR0_EXIT_BIT])
					begin
						state_nxt = DPC_ST_PRE_PD_FAST;
					end
					else
					begin
						state_nxt = DPC_ST_PRE_PD_SLOW;
					end
				end
			end
			DPC_ST_ACT_PD, DPC_ST_PRE_PD_FAST:
			begin
				if (cke && idle_cmd)
				begin
					state_nxt = DPC_ST_IDLE;
				end
			end
			DPC_ST_PRE_PD_SLOW:
			begin
				if (cke && idle_cmd)
				begin
					state_nxt = DPC_ST_IDLE;
					relock_nxt = DPC_RELOCK_CNT;
				end
			end
			DPC_ST_SELF_REF:
			begin
				if (cke && idle_cmd)
				begin
					state_nxt = DPC_ST_IDLE;
				end
			end
			default:
			begin
				state_nxt = DPC_ST_RESET;
			end
		endcase
		if (!reset_s)
		begin
			state_nxt = DPC_ST_RESET;
			relock_nxt = 4'h0;
			refcnt_nxt = DPC_REFCNT_RESET;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			state_r <= DPC_ST_RESET;
			relock_r <= 4'h0;
			refcnt_r <= DPC_REFCNT_RESET;
		end
		else
		begin
			state_r <= state_nxt;
			relock_r <= relock_nxt;
			refcnt_r <= refcnt_nxt;
		end
	end

	// ****************************************
	// mode registers
	// ****************************************
	always_comb
	begin
		mr0_nxt = mr0_r;
		mr1_nxt = mr1_r;
		mr2_nxt = mr2_r;
		if (!reset_s)
		begin
			mr0_nxt = DPC_MR_RESET;
			mr1_nxt = DPC_MR_RESET;
			mr2_nxt = DPC_MR_RESET;
		end
		else if (mr_load && state_r == DPC_ST_IDLE)
		begin
			case (mr_sel)
				2'h0: mr0_nxt = mr_data;
				2'h1: mr1_nxt = mr_data;
				2'h2: mr2_nxt = mr_data;
				default: mr0_nxt = mr0_r;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			mr0_r <= DPC_MR_RESET;
			mr1_r <= DPC_MR_RESET;
			mr2_r <= DPC_MR_RESET;
		end
		else
		begin
			mr0_r <= mr0_nxt;
			mr1_r <= mr1_nxt;
			mr2_r <= mr2_nxt;
		end
	end

	// ****************************************
	// termination control
	// ****************************************
	// nominal enable from any of the three mode bits
	assign nom_en = mr1_r[DPC_MR1_RTT_B0] | mr1_r[DPC_MR1_RTT_B1] | mr1_r[DPC_MR1_RTT_B2];
	assign wr_en = |mr2_r[DPC_MR2_RWR_HI:DPC_MR2_RWR_LO];
	assign dll_run = (state_r != DPC_ST_PRE_PD_SLOW) && (state_r != DPC_ST_RESET) && !dll_disable;
	// pin ignored in self refresh, reset, dll-disable mode or with both modes off
	assign term_allowed = (state_r != DPC_ST_SELF_REF) && (state_r != DPC_ST_RESET)
		&& !dll_disable && (nom_en || wr_en);

	always_comb
	begin
		term_nxt = DPC_TERM_OFF;
		odt_act_nxt = 1'b0;
		if (reset_s && term_allowed && odt_s)
		begin
			odt_act_nxt = 1'b1;
			if (write_burst && wr_en)
			begin
				term_nxt = DPC_TERM_WR;
			end
			else if (nom_en)
			begin
				term_nxt = DPC_TERM_NOM;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			term_r <= DPC_TERM_OFF;
			odt_act_r <= 1'b0;
		end
		else
		begin
			term_r <= term_nxt;
			odt_act_r <= odt_act_nxt;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign wr_recovery = mr0_r[DPC_MR0_WR_HI:DPC_MR0_WR_LO];
	assign dll_on = dll_run;
	// asynchronous in slow-exit precharge power-down or while the dll is still relocking
	assign odt_async = (state_r == DPC_ST_PRE_PD_SLOW) || (relock_r != 4'h0);
	assign odt_active = odt_act_r;
	assign term_sel = term_r;
	assign out_enable = (state_r == DPC_ST_IDLE);
	assign in_reset = (state_r == DPC_ST_RESET);
	assign active_pd = (state_r == DPC_ST_ACT_PD);
	assign precharge_pd = (state_r == DPC_ST_PRE_PD_FAST) || (state_r == DPC_ST_PRE_PD_SLOW);
	assign slow_exit = (state_r == DPC_ST_PRE_PD_SLOW);
	assign relock_busy = (relock_r != 4'h0);
	assign refresh_count = refcnt_r;
endmodule
`default_nettype wire

// *** rtl/dpc_pkg.sv ***
/*
 * constants and types for the dram power-down, reset and termination control block.
 * assumes a 10 MHz core clock; no bus, all control bits are plain ports.
 */
package dpc_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int DPC_CLK_PERIOD_NS = 100;
	localparam int DPC_RESET_MIN_NS = 100;
	localparam int DPC_RESET_MIN_CYC = (DPC_RESET_MIN_NS + DPC_CLK_PERIOD_NS - 1) / DPC_CLK_PERIOD_NS;
	localparam int DPC_RELOCK_NS = 24;
	localparam int DPC_RELOCK_MIN_CK = 10;
	localparam int DPC_RELOCK_NS_CYC = (DPC_RELOCK_NS + DPC_CLK_PERIOD_NS - 1) / DPC_CLK_PERIOD_NS;
	localparam int DPC_RELOCK_CYC = (DPC_RELOCK_MIN_CK > DPC_RELOCK_NS_CYC) ?
		DPC_RELOCK_MIN_CK : DPC_RELOCK_NS_CYC;
	localparam logic [3:0] DPC_RELOCK_CNT = 4'(DPC_RELOCK_CYC);

	// ****************************************
	// mode register fields
	// ****************************************
	localparam int DPC_MR0_EXIT_BIT = 12;
	localparam int DPC_MR0_WR_LO = 9;
	localparam int DPC_MR0_WR_HI = 11;
	localparam int DPC_MR1_RTT_B0 = 2;
	localparam int DPC_MR1_RTT_B1 = 6;
	localparam int DPC_MR1_RTT_B2 = 9;
	localparam int DPC_MR2_RWR_LO = 9;
	localparam int DPC_MR2_RWR_HI = 10;
	localparam logic [15:0] DPC_MR_RESET = 16'h0000;

	// ****************************************
	// command codes {cs_n, ras_n, cas_n, we_n}
	// ****************************************
	localparam logic [3:0] DPC_CMD_NOP = 4'h7;
	localparam logic [3:0] DPC_CMD_DES_MASK = 4'h8;
	localparam logic [3:0] DPC_CMD_REF = 4'h1;
	localparam logic [3:0] DPC_CMD_SREF = 4'h1;

	// ****************************************
	// termination selector codes
	// ****************************************
	localparam logic [1:0] DPC_TERM_OFF = 2'h0;
	localparam logic [1:0] DPC_TERM_NOM = 2'h1;
	localparam logic [1:0] DPC_TERM_WR = 2'h2;

	localparam logic [15:0] DPC_REFCNT_RESET = 16'h0000;

	typedef enum logic [5:0] {
		DPC_ST_RESET = 6'b000001,
		DPC_ST_IDLE = 6'b000010,
		DPC_ST_ACT_PD = 6'b000100,
		DPC_ST_PRE_PD_FAST = 6'b001000,
		DPC_ST_PRE_PD_SLOW = 6'b010000,
		DPC_ST_SELF_REF = 6'b100000
	} dpc_state_t;

endpackage

// *** rtl/dpc_sync.sv ***
/*
 * three-stage input synchroniser with agreement filter.
 * assumes the input is asynchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module dpc_sync
#(
	parameter logic RST_VAL = 1'b0
)
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic out_r;
	logic out_nxt;

	// ****************************************
	// filter: change only once stages two and three agree
	// ****************************************
	always_comb
	begin
		out_nxt = out_r;
		if (s2_r == s3_r)
		begin
			out_nxt = s3_r;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			out_r <= RST_VAL;
		end
		else
		begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			out_r <= out_nxt;
		end
	end

	assign sync_out = out_r;
endmodule
`default_nettype wire

// *** dv/dpc_ctrl_sva.sv ***
/* port checker for dpc_ctrl power-down, reset and termination control.
   assumes one core_clk domain and a synchronous active-low rst_n. */
`timescale 1ns/1ps
`default_nettype none
module dpc_ctrl_sva
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic dram_reset_n,
	input wire logic cke,
	input wire logic [3:0] cmd,
	input wire logic cmd_busy,
	input wire logic [7:0] bank_open,
	input wire logic dll_disable,
	input wire logic dll_on,
	input wire logic odt_async,
	input wire logic odt_active,
	input wire logic [1:0] term_sel,
	input wire logic out_enable,
	input wire logic in_reset,
	input wire logic active_pd,
	input wire logic precharge_pd,
	input wire logic slow_exit,
	input wire logic relock_busy,
	input wire logic [15:0] refresh_count
);
	import dpc_pkg::*;
	// ****
	// power-down entry, exit, reset and termination checks
	// ****
	wire logic nop_w = (cmd == DPC_CMD_NOP) || cmd[3];
	wire logic go_w = out_enable && !relock_busy && !cke && nop_w;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	a_open_entry: assert property (go_w && !cmd_busy && (|bank_open) |=> active_pd)
		else $error("no active power-down");
	a_closed_entry: assert property (go_w && !cmd_busy && bank_open == 8'h00 |=> precharge_pd)
		else $error("no precharge power-down");
	a_exit_kind: assert property (precharge_pd |-> slow_exit == !dll_on)
		else $error("exit kind and dll disagree");
	a_active_dll: assert property (active_pd |-> dll_on && !slow_exit)
		else $error("active power-down lost dll");
	a_pd_exit: assert property ((active_pd || precharge_pd) && cke && nop_w |=> out_enable)
		else $error("power-down not left");
	a_reset_quiet: assert property (in_reset |-> !out_enable && term_sel == DPC_TERM_OFF
		&& refresh_count == 16'h0000)
		else $error("reset state not quiet");
	a_reset_entry: assert property (!dram_reset_n [*6] |-> in_reset)
		else $error("reset pin ignored");
	a_slow_odt: assert property (precharge_pd && slow_exit |-> odt_async)
		else $error("termination not asynchronous");
	a_dll_odt: assert property (dll_disable ##1 dll_disable |-> !odt_active)
		else $error("termination with dll disabled");
endmodule
bind dpc_ctrl dpc_ctrl_sva u_dpc_ctrl_sva (.core_clk(core_clk), .rst_n(rst_n),
	.dram_reset_n(dram_reset_n), .cke(cke), .cmd(cmd), .cmd_busy(cmd_busy),
	.bank_open(bank_open), .dll_disable(dll_disable), .dll_on(dll_on), .odt_async(odt_async),
	.odt_active(odt_active), .term_sel(term_sel), .out_enable(out_enable), .in_reset(in_reset),
	.active_pd(active_pd), .precharge_pd(precharge_pd), .slow_exit(slow_exit),
	.relock_busy(relock_busy), .refresh_count(refresh_count));
`default_nettype wire

// *** dv/dpc_host.sv ***
/* host controller model driving cke, command, reset and termination pins.
   assumes core_clk from the bench; pins move on its falling edge. */
`timescale 1ns/1ps
`default_nettype none
module dpc_host
(
	input wire logic core_clk,
	output var logic cke,
	output var logic [3:0] cmd,
	output var logic dram_reset_n,
	output var logic odt_pin
);
	import dpc_pkg::*;
	// ****
	// pin sequences
	// ****
	initial
	begin
		cke = 1'b1;
		cmd = DPC_CMD_NOP;
		dram_reset_n = 1'b1;
		odt_pin = 1'b0;
	end
	task automatic step(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic issue(input logic [3:0] c, input logic k);
		cmd = c;
		cke = k;
		step(1);
		cmd = DPC_CMD_NOP;
		step(3);
	endtask
	task automatic settle();
		step(DPC_RELOCK_CYC + 1);
	endtask
	task automatic odt(input logic v);
		odt_pin = v;
		step(6);
	endtask
	task automatic pin_reset(input logic v);
		cke = 1'b0;
		dram_reset_n = v;
		step(2);
		cke = v;
		step(8);
	endtask
endmodule
`default_nettype wire

// *** dv/dpc_ctrl_tb.sv ***
/* self-checking bench for dpc_ctrl with the host pin model.
   assumes dpc_pkg, the host model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module dpc_ctrl_tb;
	import dpc_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n;
	logic cmd_busy;
	logic mr_load;
	logic dll_disable;
	logic write_burst;
	logic [7:0] bank_open;
	logic [1:0] mr_sel;
	logic [15:0] mr_data;
	logic cke, dram_reset_n, odt_pin, dll_on, odt_async, odt_active, out_enable, in_reset;
	logic active_pd, precharge_pd, slow_exit, relock_busy;
	logic [3:0] cmd;
	logic [2:0] wr_recovery;
	logic [1:0] term_sel;
	logic [15:0] refresh_count;
	int n_fail = 0;
	int cmp_count = 0;
	always #50 core_clk = ~core_clk;
	dpc_host u_dpc_host (.core_clk(core_clk), .cke(cke), .cmd(cmd), .dram_reset_n(dram_reset_n),
		.odt_pin(odt_pin));
	dpc_ctrl u_dpc_ctrl (.core_clk(core_clk), .rst_n(rst_n), .dram_reset_n(dram_reset_n),
		.cke(cke), .cmd(cmd), .cmd_busy(cmd_busy), .bank_open(bank_open), .mr_load(mr_load),
		.mr_sel(mr_sel), .mr_data(mr_data), .dll_disable(dll_disable), .write_burst(write_burst),
		.odt_pin(odt_pin), .wr_recovery(wr_recovery), .dll_on(dll_on), .odt_async(odt_async),
		.odt_active(odt_active), .term_sel(term_sel), .out_enable(out_enable),
		.in_reset(in_reset), .active_pd(active_pd), .precharge_pd(precharge_pd),
		.slow_exit(slow_exit), .relock_busy(relock_busy), .refresh_count(refresh_count));
	// ****
	// checks and scenarios
	// ****
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
		cmp_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		if (n_fail == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic mr(input logic [1:0] s, input logic [15:0] d);
		mr_sel = s;
		mr_data = d;
		mr_load = 1'b1;
		u_dpc_host.step(1);
		mr_load = 1'b0;
		u_dpc_host.step(1);
	endtask
	task automatic t_reset();
		mr(2'h0, 16'h0a00);
		u_dpc_host.issue(DPC_CMD_REF, 1'b1);
		chk(refresh_count, 16'h0001, "ref_count");
		bank_open = 8'h01;
		u_dpc_host.issue(DPC_CMD_NOP, 1'b0);
		chk(16'(active_pd), 16'h0001, "pd_before_reset");
		u_dpc_host.pin_reset(1'b0);
		chk(16'(in_reset), 16'h0001, "in_reset");
		chk(16'(active_pd), 16'h0000, "pd_left");
		chk(16'({out_enable, term_sel}), 16'h0000, "quiet");
		chk(refresh_count, 16'h0000, "ref_clear");
		chk(16'(wr_recovery), 16'h0000, "mr_clear");
		u_dpc_host.pin_reset(1'b1);
		chk(16'(out_enable), 16'h0001, "reset_release");
		bank_open = 8'h00;
	endtask
	task automatic t_pd(input logic [7:0] b, input logic f);
		logic a;
		logic s;
		a = |b;
		s = !a && !f;
		mr(2'h0, {3'h0, f, 12'ha00});
		chk(16'(wr_recovery), 16'h0005, "wr_recovery");
		bank_open = b;
		u_dpc_host.issue(DPC_CMD_NOP, 1'b0);
		chk(16'(active_pd), 16'(a), "active_pd");
		chk(16'(precharge_pd), 16'(!a), "precharge_pd");
		chk(16'({dll_on, slow_exit}), 16'({!s, s}), "dll_exit");
		chk(16'(odt_async), 16'(s), "odt_async");
		u_dpc_host.issue(DPC_CMD_NOP, 1'b1);
		chk(16'(out_enable), 16'h0001, "out_enable");
		chk(16'({odt_async, relock_busy}), 16'({s, s}), "relock_odt");
		u_dpc_host.step(DPC_RELOCK_CYC - 4);
		chk(16'(relock_busy), 16'(s), "relock_last");
		u_dpc_host.step(1);
		chk(16'({odt_async, relock_busy}), 16'h0000, "relock_done");
		bank_open = 8'h00;
	endtask
	task automatic t_busy();
		cmd_busy = 1'b1;
		u_dpc_host.issue(DPC_CMD_NOP, 1'b0);
		chk(16'(out_enable), 16'h0001, "busy_idle");
		cmd_busy = 1'b0;
		u_dpc_host.step(2);
		chk(16'(precharge_pd), 16'h0001, "late_entry");
		u_dpc_host.issue(DPC_CMD_NOP, 1'b1);
		chk(16'(out_enable), 16'h0001, "busy_exit");
		u_dpc_host.settle();
	endtask
	task automatic t_term();
		mr(2'h1, 16'h0004);
		mr(2'h2, 16'h0200);
		u_dpc_host.odt(1'b1);
		chk(16'({odt_active, term_sel}), 16'({1'b1, DPC_TERM_NOM}), "term_nom");
		write_burst = 1'b1;
		u_dpc_host.step(2);
		chk(16'(term_sel), 16'(DPC_TERM_WR), "term_wr");
		write_burst = 1'b0;
		dll_disable = 1'b1;
		u_dpc_host.step(2);
		chk(16'(odt_active), 16'h0000, "dll_off");
		dll_disable = 1'b0;
		u_dpc_host.issue(DPC_CMD_SREF, 1'b0);
		chk(16'(odt_active), 16'h0000, "self_ref");
		u_dpc_host.issue(DPC_CMD_NOP, 1'b1);
		u_dpc_host.settle();
		mr(2'h1, 16'h0000);
		mr(2'h2, 16'h0000);
		u_dpc_host.step(2);
		chk(16'(odt_active), 16'h0000, "mr_off");
		u_dpc_host.odt(1'b0);
	endtask
	initial
	begin
		rst_n = 1'b0;
		cmd_busy = 1'b0;
		mr_load = 1'b0;
		dll_disable = 1'b0;
		write_burst = 1'b0;
		bank_open = 8'h00;
		mr_sel = 2'h0;
		mr_data = 16'h0000;
		u_dpc_host.step(20);
		rst_n = 1'b1;
		u_dpc_host.step(8);
		t_reset();
		t_pd(8'h00, 1'b0);
		t_pd(8'h00, 1'b1);
		t_pd(8'h80, 1'b0);
		t_busy();
		t_term();
		conclude();
	end
	initial
	begin
		#200000;
		n_fail++;
		conclude();
	end
endmodule
`default_nettype wire
